/* hw/lvd_regs.svh */
`ifndef LVD_REGS_SVH
`define LVD_REGS_SVH

// ==========================================================================
// Register word indices, taken from haddr[11:2].
// ==========================================================================
`define IDX_CTRL      10'h000
`define IDX_STATUS    10'h001
`define IDX_SET       10'h002
`define IDX_MASK      10'h003
`define F_WORD_IDX    11:2

// ==========================================================================
// Field positions of the control register.
// ==========================================================================
`define F_TRIP        2:0
`define B_BGBUF       3
`define B_DET_EN      4
`define B_LOW_FLAG    5
`define F_FILTER      7:6

// ==========================================================================
// Field positions of status, set and mask registers.
// ==========================================================================
`define B_REQUEST     0
`define B_IRQ_EN      0
`define B_GLOBAL_EN   1

// ==========================================================================
// Reset values and filter limits in slow clock edges.
// ==========================================================================
`define CTRL_RESET    8'h00
`define LIMIT_SHORT   4'h2
`define LIMIT_MID     4'h4
`define LIMIT_LONG    4'h8
`define RDATA_ZERO    32'h0000_0000
`define CNT_ZERO      4'h0
`define CNT_STEP      4'h1

`endif

/* hw/lvd_pkg.sv */
// ==========================================================================
// Shared types of the supply monitor.
// ==========================================================================
`default_nettype none

package lvd_pkg;

   // Operating mode of the core, as reported by the power manager.
   typedef enum logic [1:0] {
      MODE_FAST,
      MODE_SLOW,
      MODE_IDLE,
      MODE_SLEEP
   } power_mode_t;

   // Whole state of the block in one record.
   typedef struct packed {
      logic [2:0]  trip;      // Trip level code.
      logic        bgbuf;     // Bandgap buffer enable.
      logic        det_en;    // Detector enable.
      logic [1:0]  filt;      // Low-time filter code.
      logic        flag;      // Interrupt request flag.
      logic        irq_en;    // Request enable.
      logic        gie;       // Global interrupt enable.
      logic        sync1;     // First synchroniser stage.
      logic        sync2;     // Second synchroniser stage.
      logic        rc_prev;   // Previous slow clock sample.
      logic [3:0]  cnt;       // Slow clock edges seen while low.
      logic        wr_pend;   // Write data phase due.
      logic        rd_pend;   // Read wait cycle due.
      logic [9:0]  idx;       // Word index of pending access.
      logic [31:0] hrdata;    // Read data.
      logic        hready;    // Ready to the bus.
      logic        det_on;    // Detector powered.
      logic        bg_on;     // Bandgap powered.
      logic        irq;       // Interrupt output.
      logic        wake;      // Wake pulse.
   } lvd_state_t;

endpackage

`default_nettype wire

/* hw/supply_low_voltage_detector.sv */
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_regs.svh"

// ==========================================================================
// Supply monitor control, status and filtered interrupt.
// ==========================================================================
module supply_low_voltage_detector (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic                 comparator_out,
   input  wire logic                 slow_rc_clock,
   input  wire lvd_pkg::power_mode_t power_mode,
   input  wire logic                 brownout_reset_enable,
   output logic      [2:0]           trip_level_select,
   output logic                      detector_on,
   output logic                      bandgap_on,
   output logic                      irq,
   output logic                      wake
);
   import lvd_pkg::*;

   // ========================================================================
   // State and helpers.
   // ========================================================================
   lvd_state_t s_r;        // Registered state.
   lvd_state_t s_nxt;      // Next state.
   logic       rc_edge;    // Rising edge of the slow clock.
   logic       low;        // Qualified supply-low level.
   logic       hw_set;     // Filter has run out; request is due.
   logic       sw_clr;     // Software clears the request.
   logic       sw_set;     // Software sets the request.
   logic       accept;     // Address phase taken this cycle.
   logic [3:0] limit;      // Edges needed for the chosen filter.

   // Slow clock edges needed; every edge count spans one period of doubt.
   function automatic logic [3:0] filter_limit(input logic [1:0] code);
      unique case (code)
         2'h1:    filter_limit = `LIMIT_MID;
         2'h2:    filter_limit = `LIMIT_LONG;
         default: filter_limit = `LIMIT_SHORT;
      endcase
   endfunction

   // Read view of each register; unmapped words read as zero.
   function automatic logic [31:0] reg_read(input lvd_state_t st,
                                            input logic [9:0] idx);
      logic [31:0] d;
      d = `RDATA_ZERO;
      unique case (idx)
         `IDX_CTRL: begin
            d[`F_TRIP]     = st.trip;
            d[`B_BGBUF]    = st.bgbuf;
            d[`B_DET_EN]   = st.det_en;
            d[`B_LOW_FLAG] = st.sync2 & st.det_on;
            d[`F_FILTER]   = st.filt;
         end
         `IDX_STATUS: begin
            d[`B_REQUEST] = st.flag;
         end
         `IDX_MASK: begin
            d[`B_IRQ_EN]    = st.irq_en;
            d[`B_GLOBAL_EN] = st.gie;
         end
         default: begin
            d = `RDATA_ZERO;
         end
      endcase
      return d;
   endfunction

   // ========================================================================
   // Next-state logic.
   // ========================================================================
   // One process computes the whole next state so that every field has a
   // single driver and the priorities stay visible in one place.
   always_comb begin
      s_nxt = s_r;
      sw_clr = 1'b0;
      sw_set = 1'b0;

      // The comparator is asynchronous; only the second stage is used.
      s_nxt.sync1 = comparator_out;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.rc_prev = slow_rc_clock;
      rc_edge = slow_rc_clock & ~s_r.rc_prev;

      // A switched-off detector reports no low supply at all.
      low = s_r.sync2 & s_r.det_on;
      limit = filter_limit(s_r.filt);

      // Count slow clock edges while low; any high sample restarts.
      if (!low) begin
         s_nxt.cnt = `CNT_ZERO;
      end else if (rc_edge && (s_r.cnt != limit)) begin
         s_nxt.cnt = s_r.cnt + `CNT_STEP;
      end
      hw_set = low & rc_edge & (s_r.cnt == (limit - `CNT_STEP));

      // Bus address phase; the single slave's ready is the bus ready.
      accept = hsel & htrans[1] & hready;

      // Write data phase: commit with the data now on hwdata.
      if (s_r.wr_pend) begin
         s_nxt.wr_pend = 1'b0;
         unique case (s_r.idx)
            `IDX_CTRL: begin
               s_nxt.trip   = hwdata[`F_TRIP];
               s_nxt.bgbuf  = hwdata[`B_BGBUF];
               s_nxt.det_en = hwdata[`B_DET_EN];
               s_nxt.filt   = hwdata[`F_FILTER];
            end
            `IDX_STATUS: begin
               sw_clr = hwdata[`B_REQUEST];
            end
            `IDX_SET: begin
               // Lets software preset the request before idle.
               sw_set = hwdata[`B_REQUEST];
            end
            `IDX_MASK: begin
               s_nxt.irq_en = hwdata[`B_IRQ_EN];
               s_nxt.gie    = hwdata[`B_GLOBAL_EN];
            end
            default: begin
               sw_clr = 1'b0;
            end
         endcase
      end

      // A read waits one cycle so that a write just before it is seen.
      if (s_r.rd_pend) begin
         s_nxt.hrdata  = reg_read(s_r, s_r.idx);
         s_nxt.hready  = 1'b1;
         s_nxt.rd_pend = 1'b0;
      end

      // Take a new address phase; only whole words are expected.
      if (accept) begin
         s_nxt.idx = haddr[`F_WORD_IDX];
         if (hwrite) begin
            s_nxt.wr_pend = 1'b1;
         end else begin
            s_nxt.rd_pend = 1'b1;
            s_nxt.hready  = 1'b0;
         end
      end

      // Set wins over a clear arriving in the same cycle.
      s_nxt.flag = (s_r.flag & ~sw_clr) | sw_set | hw_set;

      // Sleep overrides the enable; other modes follow it.
      s_nxt.det_on = s_r.det_en & (power_mode != MODE_SLEEP);
      s_nxt.bg_on = s_nxt.det_on | brownout_reset_enable | s_r.bgbuf;

      // Interrupt needs its own enable and the global enable.
      s_nxt.irq = s_nxt.flag & s_nxt.irq_en & s_nxt.gie;

      // Only a fresh hardware setting wakes; a preset flag stays quiet.
      s_nxt.wake = hw_set & ~s_r.flag & (power_mode == MODE_IDLE);
   end

   // ========================================================================
   // State register.
   // ========================================================================
   // Reset gives constants only; hready starts high so the bus can begin.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r        <= '0;
         s_r.hready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ========================================================================
   // Outputs, each taken from a state flip-flop except hresp, which is tied to zero.
   // ========================================================================
   assign hrdata            = s_r.hrdata;
   assign hreadyout         = s_r.hready;
   assign hresp             = 1'b0;
   assign trip_level_select = s_r.trip;
   assign detector_on       = s_r.det_on;
   assign bandgap_on        = s_r.bg_on;
   assign irq               = s_r.irq;
   assign wake              = s_r.wake;

   // ========================================================================
   // Assertions.
   // ========================================================================
   // A control write in its data phase shows its level code one edge later.
   property p_trip;
      @(posedge hclk) disable iff (!hresetn)
         (s_r.wr_pend && (s_r.idx == `IDX_CTRL)) |=>
         (trip_level_select == $past(hwdata[`F_TRIP]));
   endproperty
   a_trip: assert property (p_trip) else $error("trip level not taken");

   // A read of control returns the synchronised low flag.
   property p_low_read;
      @(posedge hclk) disable iff (!hresetn)
         (s_r.rd_pend && (s_r.idx == `IDX_CTRL)) |=>
         (hrdata[`B_LOW_FLAG] == $past(s_r.sync2 & s_r.det_on)) && hreadyout;
   endproperty
   a_low_read: assert property (p_low_read) else $error("low flag read wrong");

   // Sleep always turns the detector off.
   property p_sleep_off;
      @(posedge hclk) disable iff (!hresetn)
         (power_mode == MODE_SLEEP) |=> !detector_on;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("detector on in sleep");

   // Outside sleep the detector follows its enable.
   property p_follow_en;
      @(posedge hclk) disable iff (!hresetn)
         (power_mode != MODE_SLEEP) |=> (detector_on == $past(s_r.det_en));
   endproperty
   a_follow_en: assert property (p_follow_en) else $error("enable ignored");

   // Without a low level only software can raise the request.
   property p_no_short;
      @(posedge hclk) disable iff (!hresetn)
         (!(s_r.sync2 && s_r.det_on) && !sw_set) |=> !$rose(s_r.flag);
   endproperty
   a_no_short: assert property (p_no_short) else $error("request without low");

   // The shortest filter needs at least two slow clock edges.
   property p_filter_len;
      @(posedge hclk) disable iff (!hresetn)
         hw_set |-> (s_r.cnt == (filter_limit(s_r.filt) - `CNT_STEP)) && (s_r.cnt != `CNT_ZERO);
   endproperty
   a_filter_len: assert property (p_filter_len) else $error("filter too short");

   // A fresh request in idle wakes the core on the next edge.
   property p_wake;
      @(posedge hclk) disable iff (!hresetn)
         (hw_set && !s_r.flag && (power_mode == MODE_IDLE)) |=> wake;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake from idle");

   // Bandgap comes on whenever brownout or the buffer bit asks for it.
   property p_bandgap;
      @(posedge hclk) disable iff (!hresetn)
         (brownout_reset_enable || s_r.bgbuf) |=> bandgap_on;
   endproperty
   a_bandgap: assert property (p_bandgap) else $error("bandgap off");

   // Interrupt only with both enables.
   property p_irq_gate;
      @(posedge hclk) disable iff (!hresetn)
         irq |-> (s_r.flag && s_r.irq_en && s_r.gie);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("ungated interrupt");

   // A comparator steady for three edges is seen as low.
   property p_sync;
      @(posedge hclk) disable iff (!hresetn)
         comparator_out [*3] |-> s_r.sync2;
   endproperty
   a_sync: assert property (p_sync) else $error("synchroniser stuck");

   // A low that ends empties the filter, so a new low starts afresh.
   property p_restart;
      @(posedge hclk) disable iff (!hresetn)
         !(s_r.sync2 && s_r.det_on) |=> (s_r.cnt == `CNT_ZERO);
   endproperty
   a_restart: assert property (p_restart) else $error("filter not restarted");

   // The request never follows a low that has only just begun.
   // Guards against a count left over from an earlier low episode.
   property p_low_held;
      @(posedge hclk) disable iff (!hresetn)
         hw_set |-> $past(s_r.sync2 && s_r.det_on);
   endproperty
   a_low_held: assert property (p_low_held) else $error("request on a fresh low");

   // With buffer and brownout off, the bandgap follows the detector alone.
   property p_bandgap_off;
      @(posedge hclk) disable iff (!hresetn)
         (!brownout_reset_enable && !s_r.bgbuf) |=> (bandgap_on == detector_on);
   endproperty
   a_bandgap_off: assert property (p_bandgap_off) else $error("bandgap source wrong");

   // A pulse on the wake line lasts a single cycle.
   property p_wake_pulse;
      @(posedge hclk) disable iff (!hresetn)
         wake |=> !wake;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

   // A request that is already pending never wakes the core again.
   property p_no_rewake;
      @(posedge hclk) disable iff (!hresetn)
         s_r.flag |=> !wake;
   endproperty
   a_no_rewake: assert property (p_no_rewake) else $error("wake from pending request");

   // Writing a one to the status word clears a request with no new event.
   property p_clear;
      @(posedge hclk) disable iff (!hresetn)
         (s_r.wr_pend && (s_r.idx == `IDX_STATUS) && hwdata[`B_REQUEST] && !hw_set)
         |=> !s_r.flag;
   endproperty
   a_clear: assert property (p_clear) else $error("request not cleared");

   // Both enables and a pending request always reach the pin.
   property p_irq_on;
      @(posedge hclk) disable iff (!hresetn)
         (s_r.flag && s_r.irq_en && s_r.gie) |-> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt missing");

   // Main scenarios.
   property p_cov_set;
      @(posedge hclk) disable iff (!hresetn) hw_set;
   endproperty
   c_cov_set: cover property (p_cov_set);

   property p_cov_wake;
      @(posedge hclk) disable iff (!hresetn) wake;
   endproperty
   c_cov_wake: cover property (p_cov_wake);

   property p_cov_irq;
      @(posedge hclk) disable iff (!hresetn) $rose(irq);
   endproperty
   c_cov_irq: cover property (p_cov_irq);

   property p_cov_read;
      @(posedge hclk) disable iff (!hresetn) s_r.rd_pend ##1 hreadyout;
   endproperty
   c_cov_read: cover property (p_cov_read);

   property p_cov_sleep;
      @(posedge hclk) disable iff (!hresetn) s_r.det_en && (power_mode == MODE_SLEEP);
   endproperty
   c_cov_sleep: cover property (p_cov_sleep);

endmodule

`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Self-checking bench of the supply monitor, driven over its bus.
// ==========================================================================
module tb;
   import lvd_pkg::*;

   // Byte addresses of the four registers and one hole in the map.
   localparam logic [31:0] A_CTRL = 32'h0000_0000;
   localparam logic [31:0] A_STAT = 32'h0000_0004;
   localparam logic [31:0] A_SET  = 32'h0000_0008;
   localparam logic [31:0] A_MASK = 32'h0000_000c;
   localparam logic [31:0] A_NONE = 32'h0000_0010;

   logic        hclk          = 1'b0;          // System clock.
   logic        hresetn       = 1'b0;          // Bus reset, active low.
   logic        hsel          = 1'b0;          // Slave select.
   logic [31:0] haddr         = 32'h0;         // Bus address.
   logic [1:0]  htrans        = 2'h0;          // Transfer type.
   logic        hwrite        = 1'b0;          // Write strobe.
   logic [31:0] hwdata        = 32'h0;         // Write data.
   logic [31:0] hrdata;                        // Read data.
   logic        hreadyout;                     // Slave ready.
   logic        hresp;                         // Slave response.
   logic        comparator_out = 1'b0;         // High while supply is low.
   logic        slow_rc_clock  = 1'b0;         // Slow clock, idle low.
   power_mode_t power_mode     = MODE_FAST;    // Core mode.
   logic        brownout_reset_enable = 1'b0;  // Brownout reset enable.
   logic [2:0]  trip_level_select;             // Trip code seen outside.
   logic        detector_on;                   // Detector power.
   logic        bandgap_on;                    // Bandgap power.
   logic        irq;                           // Interrupt level.
   logic        wake;                          // Wake pulse.
   logic [31:0] wake_cnt      = 32'h0;         // Wake pulses seen.
   int          fails         = 0;             // Mismatches.
   int          checks        = 0;             // Comparisons.

   // Half period of 25 ns gives the 20 MHz system clock.
   always #25 hclk = ~hclk;

   // Count wake pulses, so that a stuck-high pulse shows as many.
   always @(posedge hclk) begin
      if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 32'h1;
      end
   end

   supply_low_voltage_detector dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .comparator_out(comparator_out),
      .slow_rc_clock(slow_rc_clock), .power_mode(power_mode),
      .brownout_reset_enable(brownout_reset_enable),
      .trip_level_select(trip_level_select), .detector_on(detector_on),
      .bandgap_on(bandgap_on), .irq(irq), .wake(wake));

   // ======================================================================
   // Shared tasks.
   // ======================================================================
   // Compare and count; a mismatch is printed at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Ready is registered, so its value before the edge is the one sampled.
   task automatic wait_rdy(output logic [31:0] d);
      logic r;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge hclk);
         r = hreadyout;
         d = hrdata;
         @(posedge hclk);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] t;
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b1; htrans <= 2'h2;
      wait_rdy(t);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      wait_rdy(t);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= 1'b0; htrans <= 2'h2;
      wait_rdy(d);
      hsel <= 1'b0; htrans <= 2'h0;
      wait_rdy(d);
   endtask

   // Rising edges of the slow clock, each four system cycles high and low.
   task automatic slow(input int n);
      repeat (n) begin
         slow_rc_clock <= 1'b1; cyc(4);
         slow_rc_clock <= 1'b0; cyc(4);
      end
   endtask

   // ======================================================================
   // Scenarios.
   // ======================================================================
   task automatic t_reset;
      logic [31:0] d;
      rd(A_CTRL, d); chk(d, 32'h0);
      rd(A_STAT, d); chk(d, 32'h0);
      rd(A_MASK, d); chk(d, 32'h0);
      wr(A_NONE, 32'hffff_ffff);
      rd(A_NONE, d); chk(d, 32'h0);
      rd(A_CTRL, d); chk(d, 32'h0);
      chk({31'h0, hresp}, 32'h0);
   endtask

   // Every trip code; a write of one to the read-only flag must not stick.
   task automatic t_ctrl;
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         wr(A_CTRL, 32'h20 | i);
         cyc(1); @(negedge hclk);
         chk({29'h0, trip_level_select}, i);
         @(posedge hclk);
         rd(A_CTRL, d); chk(d, i);
      end
   endtask

   task automatic t_power;
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         brownout_reset_enable <= i[2];
         wr(A_CTRL, {27'h0, i[0], i[1], 3'h0});
         cyc(2); @(negedge hclk);
         chk({31'h0, detector_on}, i[0]);
         chk({31'h0, bandgap_on}, i != 0);
         @(posedge hclk);
      end
      brownout_reset_enable <= 1'b0;
      wr(A_CTRL, 32'h10);
      comparator_out <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         power_mode <= power_mode_t'(m[1:0]);
         cyc(4); @(negedge hclk);
         chk({31'h0, detector_on}, m != 3);
         chk({31'h0, bandgap_on}, m != 3);
         @(posedge hclk);
      end
      // Sleep leaves the supply-low flag dark even with the supply low.
      rd(A_CTRL, d); chk(d, 32'h10);
      comparator_out <= 1'b0; power_mode <= MODE_FAST;
      cyc(4);
   endtask

   // Each filter code: one edge short fails, even after a restart.
   task automatic t_filter;
      logic [31:0] d;
      int n;
      for (int c = 0; c < 4; c++) begin
         n = (c == 2) ? 8 : (c == 1) ? 4 : 2;
         wr(A_CTRL, (c << 6) | 32'h10);
         wr(A_STAT, 32'h1);
         comparator_out <= 1'b1; cyc(4);
         rd(A_CTRL, d); chk(d, (c << 6) | 32'h30);
         slow(n - 1);
         rd(A_STAT, d); chk(d, 32'h0);
         comparator_out <= 1'b0; cyc(4);
         comparator_out <= 1'b1; cyc(4);
         slow(n - 1);
         rd(A_STAT, d); chk(d, 32'h0);
         slow(1); cyc(2);
         rd(A_STAT, d); chk(d, 32'h1);
         comparator_out <= 1'b0; cyc(4);
         rd(A_CTRL, d); chk(d, (c << 6) | 32'h10);
      end
      wr(A_STAT, 32'h1);
   endtask

   // Request reaches the pin only with both enables; a one clears it.
   task automatic t_irq;
      logic [31:0] d;
      wr(A_SET, 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(A_MASK, m);
         cyc(1); @(negedge hclk);
         chk({31'h0, irq}, m == 3);
         @(posedge hclk);
      end
      wr(A_STAT, 32'h1);
      cyc(1); @(negedge hclk);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
      rd(A_STAT, d); chk(d, 32'h0);
      rd(A_MASK, d); chk(d, 32'h3);
   endtask

   // Idle wake on a filtered low; a preset request suppresses it.
   task automatic t_wake;
      logic [31:0] w0;
      wr(A_CTRL, 32'h10);
      power_mode <= MODE_IDLE;
      w0 = wake_cnt;
      comparator_out <= 1'b1; cyc(4);
      slow(2); cyc(4);
      chk(wake_cnt - w0, 32'h1);
      chk({31'h0, irq}, 32'h1);
      comparator_out <= 1'b0; cyc(4);
      wr(A_STAT, 32'h1);
      wr(A_SET, 32'h1);
      comparator_out <= 1'b1; cyc(4);
      slow(2); cyc(4);
      chk(wake_cnt - w0, 32'h1);
      comparator_out <= 1'b0; power_mode <= MODE_FAST;
      wr(A_STAT, 32'h1);
   endtask

   // ======================================================================
   // Main sequence and watchdog.
   // ======================================================================
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset; t_ctrl; t_power; t_filter; t_irq; t_wake;
      final_report;
   end

   // The whole run needs well under a thousand cycles; far more means a hang.
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      final_report;
   end

endmodule

`default_nettype wire
